//--- design/xfe_execute.sv
// exclusive-or execute slice: decodes the three xor forms and writes back a result
// assumes the decoder presents one instruction with its two read operands per cycle
// and that the write-back consumer takes the result in the cycle that valid is high
module xfe_execute
(
    input  wire logic                       sys_clk_in,
    input  wire logic                       rst_in,
    input  wire logic                       issue_in,
    input  wire logic [31:0]                instr_in,
    input  wire logic [xfe_pkg::DATA_W-1:0] first_source_reg_in,
    input  wire logic [xfe_pkg::DATA_W-1:0] second_operand_reg_in,
    output logic [xfe_pkg::IDX_W-1:0]       first_source_idx_out,
    output logic [xfe_pkg::IDX_W-1:0]       second_operand_idx_out,
    output logic                            wb_valid_out,
    output logic [xfe_pkg::IDX_W-1:0]       wb_dest_out,
    output logic [xfe_pkg::DATA_W-1:0]      wb_value_out
);
    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    logic [xfe_pkg::IDX_W-1:0]  fld_a;
    logic [xfe_pkg::IDX_W-1:0]  fld_b;
    logic [xfe_pkg::IDX_W-1:0]  register_form_dest;
    logic [xfe_pkg::OPX_W-1:0]  fld_opx;
    logic [xfe_pkg::OP_W-1:0]   fld_op;
    logic [xfe_pkg::IMM_W-1:0]  sixteen_bit_immediate;
    xfe_pkg::xfe_form_t         form;
    logic [xfe_pkg::DATA_W-1:0] operand_b;
    logic [xfe_pkg::IDX_W-1:0]  dest_sel;
    xfe_pkg::xfe_state_t        state_r;
    xfe_pkg::xfe_state_t        state_nxt;

    // slices of the instruction word
    assign fld_a   = instr_in[xfe_pkg::FLD_A_LSB +: xfe_pkg::IDX_W];
    assign fld_b   = instr_in[xfe_pkg::FLD_B_LSB +: xfe_pkg::IDX_W];
    assign register_form_dest = instr_in[xfe_pkg::FLD_C_LSB +: xfe_pkg::IDX_W];
    assign fld_opx = instr_in[xfe_pkg::FLD_OPX_LSB +: xfe_pkg::OPX_W];
    assign fld_op  = instr_in[xfe_pkg::FLD_OP_LSB +: xfe_pkg::OP_W];
    assign sixteen_bit_immediate = instr_in[xfe_pkg::FLD_IMM_LSB +: xfe_pkg::IMM_W];

    // read ports: fields a and b always, field b used as a source only in register form
    assign first_source_idx_out   = fld_a;
    assign second_operand_idx_out = fld_b;

    // ------------------------------------------------------------
    // decode and operand routing
    // ------------------------------------------------------------
    // pick the form, the second operand and the destination
    always_comb
    begin
        form      = xfe_pkg::XFE_NONE;
        operand_b = xfe_pkg::RESULT_RST;
        dest_sel  = xfe_pkg::IDX_RST;
        if (fld_op == xfe_pkg::OP_RTYPE && fld_opx == xfe_pkg::OPX_XOR)
        begin
            form = xfe_pkg::XFE_REG;
        end
        else if (fld_op == xfe_pkg::OP_XORHI)
        begin
            form = xfe_pkg::XFE_HI;
        end
        else if (fld_op == xfe_pkg::OP_XORI)
        begin
            form = xfe_pkg::XFE_LO;
        end
        case (form)
            xfe_pkg::XFE_REG:
            begin
                operand_b = second_operand_reg_in;
                dest_sel  = register_form_dest;
            end
            xfe_pkg::XFE_HI:
            begin
                operand_b = {sixteen_bit_immediate, xfe_pkg::HALF_ZERO};
                dest_sel  = fld_b;
            end
            xfe_pkg::XFE_LO:
            begin
                operand_b = {xfe_pkg::HALF_ZERO, sixteen_bit_immediate};
                dest_sel  = fld_b;
            end
            default:
            begin
                operand_b = xfe_pkg::RESULT_RST;
                dest_sel  = xfe_pkg::IDX_RST;
            end
        endcase
    end

    // ------------------------------------------------------------
    // single xor unit and write-back register
    // ------------------------------------------------------------
    // next state: hold the last value, raise valid only for a decoded issue
    always_comb
    begin
        state_nxt          = state_r;
        state_nxt.wb.valid = 1'b0;
        if (issue_in && form != xfe_pkg::XFE_NONE)
        begin
            state_nxt.wb.valid = 1'b1;
            state_nxt.wb.dest  = dest_sel;
            state_nxt.wb.value = first_source_reg_in ^ operand_b;
        end
    end

    // state register
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            state_r.wb.valid <= 1'b0;
            state_r.wb.dest  <= xfe_pkg::IDX_RST;
            state_r.wb.value <= xfe_pkg::RESULT_RST;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // registered write-back outputs
    assign wb_valid_out = state_r.wb.valid;
    assign wb_dest_out  = state_r.wb.dest;
    assign wb_value_out = state_r.wb.value;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // register form returns the xor of both read operands one cycle later
    a_reg_result: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (issue_in && fld_op == xfe_pkg::OP_RTYPE && fld_opx == xfe_pkg::OPX_XOR)
        |=> wb_valid_out && wb_value_out ==
            ($past(first_source_reg_in) ^ $past(second_operand_reg_in)))
        else $error("register form xor result wrong");

    // high form xors the immediate over the upper half
    a_hi_result: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (issue_in && fld_op == xfe_pkg::OP_XORHI)
        |=> wb_value_out == ($past(first_source_reg_in) ^ {$past(instr_in[21:6]), 16'h0000}))
        else $error("high form xor result wrong");

    // low form xors the immediate over the lower half
    a_lo_result: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (issue_in && fld_op == xfe_pkg::OP_XORI)
        |=> wb_value_out == ($past(first_source_reg_in) ^ {16'h0000, $past(instr_in[21:6])}))
        else $error("low form xor result wrong");

    // low form never smears the immediate top bit into the upper half
    a_no_sign_ext: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (issue_in && fld_op == xfe_pkg::OP_XORI)
        |=> wb_value_out[31:16] == $past(first_source_reg_in[31:16]))
        else $error("low form immediate was extended into upper half");

    // high form leaves the lower half of the source as it was
    a_hi_low_kept: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (issue_in && fld_op == xfe_pkg::OP_XORHI)
        |=> wb_value_out[15:0] == $past(first_source_reg_in[15:0]))
        else $error("high form disturbed lower half");

    // register form writes the third index field
    a_reg_dest: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (issue_in && fld_op == xfe_pkg::OP_RTYPE && fld_opx == xfe_pkg::OPX_XOR)
        |=> wb_dest_out == $past(instr_in[21:17]))
        else $error("register form destination wrong");

    // immediate forms write the second index field
    a_imm_dest: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (issue_in && (fld_op == xfe_pkg::OP_XORHI || fld_op == xfe_pkg::OP_XORI))
        |=> wb_valid_out && wb_dest_out == $past(instr_in[26:22]))
        else $error("immediate form destination wrong");

    // nothing outside the xor group raises a write-back
    a_decode_only: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !(issue_in && (fld_op == xfe_pkg::OP_XORHI || fld_op == xfe_pkg::OP_XORI
          || (fld_op == xfe_pkg::OP_RTYPE && fld_opx == xfe_pkg::OPX_XOR)))
        |=> !wb_valid_out)
        else $error("write-back raised for an instruction not in the xor group");

    // high form xors the immediate untouched into the upper half of the source
    a_hi_upper_half: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (issue_in && fld_op == xfe_pkg::OP_XORHI)
        |=> wb_value_out[31:16] == ($past(first_source_reg_in[31:16]) ^ $past(instr_in[21:6])))
        else $error("high form upper half wrong");

    // ------------------------------------------------------------
    // hold, reset and read-port assertions
    // ------------------------------------------------------------
    // an ignored cycle leaves the held destination and result untouched
    a_refused_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !(issue_in && (fld_op == xfe_pkg::OP_XORHI || fld_op == xfe_pkg::OP_XORI
          || (fld_op == xfe_pkg::OP_RTYPE && fld_opx == xfe_pkg::OPX_XOR)))
        |=> $stable(wb_dest_out) && $stable(wb_value_out))
        else $error("held write-back changed without a decoded issue");

    // reset clears the write-back port so no stale result is offered
    a_reset_clear: assert property (@(posedge sys_clk_in)
        rst_in |=> !wb_valid_out && wb_dest_out == xfe_pkg::IDX_RST
                   && wb_value_out == xfe_pkg::RESULT_RST)
        else $error("write-back not cleared by reset");

    // read indices follow fields a and b of the presented word in the same cycle
    a_idx_fields: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        first_source_idx_out == instr_in[31:27] && second_operand_idx_out == instr_in[26:22])
        else $error("register read index wrong");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    // each form, a set immediate top bit and a run of results
    c_reg_form: cover property (@(posedge sys_clk_in) disable iff (rst_in)
        issue_in && form == xfe_pkg::XFE_REG ##1 wb_valid_out);
    c_hi_form: cover property (@(posedge sys_clk_in) disable iff (rst_in)
        issue_in && form == xfe_pkg::XFE_HI ##1 wb_valid_out);
    c_lo_form: cover property (@(posedge sys_clk_in) disable iff (rst_in)
        issue_in && form == xfe_pkg::XFE_LO ##1 wb_valid_out);
    c_back_to_back: cover property (@(posedge sys_clk_in) disable iff (rst_in)
        wb_valid_out [*3]);
    c_lo_top_imm_bit: cover property (@(posedge sys_clk_in) disable iff (rst_in)
        issue_in && form == xfe_pkg::XFE_LO && sixteen_bit_immediate[15] ##1 wb_valid_out);
endmodule

//--- design/xfe_pkg.sv
// package for the exclusive-or execute slice: instruction fields and opcodes
// assumes a 32-bit instruction word with the usual R and I type layouts
package xfe_pkg;
    // ------------------------------------------------------------
    // instruction field positions
    // ------------------------------------------------------------
    localparam int FLD_A_LSB   = 27;
    localparam int FLD_B_LSB   = 22;
    localparam int FLD_C_LSB   = 17;
    localparam int FLD_OPX_LSB = 11;
    localparam int FLD_IMM_LSB = 6;
    localparam int FLD_OP_LSB  = 0;
    localparam int IDX_W       = 5;
    localparam int OPX_W       = 6;
    localparam int OP_W        = 6;
    localparam int IMM_W       = 16;
    localparam int DATA_W      = 32;

    // ------------------------------------------------------------
    // opcode values
    // ------------------------------------------------------------
    localparam logic [OP_W-1:0]  OP_RTYPE = 6'h3a;
    localparam logic [OPX_W-1:0] OPX_XOR  = 6'h1e;
    localparam logic [OP_W-1:0]  OP_XORHI = 6'h3c;
    localparam logic [OP_W-1:0]  OP_XORI  = 6'h1c;
    localparam logic [IMM_W-1:0] HALF_ZERO = 16'h0000;

    // reset values
    localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;
    localparam logic [IDX_W-1:0]  IDX_RST    = 5'h00;

    typedef enum {XFE_NONE, XFE_REG, XFE_HI, XFE_LO} xfe_form_t;

    // result carried to the register file
    typedef struct packed {
        logic              valid;
        logic [IDX_W-1:0]  dest;
        logic [DATA_W-1:0] value;
    } xfe_wb_t;

    // whole state of the slice
    typedef struct packed {
        xfe_wb_t wb;
    } xfe_state_t;
endpackage

//--- test/tb_xor_family_execute.sv
// self-checking bench for the xor execute slice
// assumes the register file partner model answers reads in the same cycle
module tb_xor_family_execute;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, rst = 1'b1, issue = 1'b0;
    logic [31:0] instr = '0, salt = '0, va, vb;
    logic [4:0]  ia, ib, dest;
    logic        valid;
    logic [31:0] value;
    logic [36:0] exp_q[$];
    logic [36:0] last = '0;
    int          mismatches = 0, comparisons = 0, seed = 86;
    always #12.5 clk = ~clk;
    xfe_execute i_dut (.sys_clk_in(clk), .rst_in(rst), .issue_in(issue), .instr_in(instr),
        .first_source_reg_in(va), .second_operand_reg_in(vb), .first_source_idx_out(ia),
        .second_operand_idx_out(ib), .wb_valid_out(valid), .wb_dest_out(dest),
        .wb_value_out(value));
    xfe_regfile_model i_rf (.rd_a_idx_in(ia), .rd_b_idx_in(ib), .salt_in(salt),
        .rd_a_out(va), .rd_b_out(vb));
    function automatic logic [31:0] rotl(logic [31:0] x, logic [4:0] i);
        return (x << i) | (x >> (6'h20 - {1'b0, i}));
    endfunction
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // form 0 reg, 1 high imm, 2 low imm, 3 wrong extended opcode, 4 not issued,
    // 5 issued with an opcode outside the xor group
    task automatic drive(int form, bit sign);
        logic [31:0] w, s, a;
        w = $random(seed);
        s = $random(seed);
        w[21] = w[21] | sign;
        w[5:0] = (form == 0 || form == 3) ? xfe_pkg::OP_RTYPE :
                 (form == 1) ? xfe_pkg::OP_XORHI :
                 (form == 5) ? (xfe_pkg::OP_XORI ^ 6'h01) : xfe_pkg::OP_XORI;
        w[16:11] = (form == 3) ? (xfe_pkg::OPX_XOR ^ 6'h01) : xfe_pkg::OPX_XOR;
        if (form == 0)
            w[21] = sign;
        a = rotl(s, w[31:27]);
        @(posedge clk);
        #1;
        instr = w;
        salt = s;
        issue = (form != 4);
        if (form == 0)
            exp_q.push_back({w[21:17], a ^ rotl(s, w[26:22])});
        else if (form == 1)
            exp_q.push_back({w[26:22], a ^ {w[21:6], 16'h0000}});
        else if (form == 2)
            exp_q.push_back({w[26:22], a ^ {16'h0000, w[21:6]}});
    endtask
    // monitor: takes the oldest note when a result appears, checks holds otherwise
    always @(negedge clk)
    begin
        if (valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("unexpected result", 32'h1, 32'h0);
            else
                last = exp_q.pop_front();
        end
        check("dest", {27'h0, dest}, {27'h0, last[36:32]});
        check("value", value, last[31:0]);
    end
    // watchdog
    initial
    begin
        #(25 * 5000);
        mismatches++;
        complete_run();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        for (int k = 0; k < 24; k++)
            drive(k % 6, (k / 6) % 2 == 1);
        $display("test directed forms done");
        for (int k = 0; k < 400; k++)
            drive($unsigned($random(seed)) % 6, 1'b0);
        drive(4, 1'b0);
        $display("test random stream done");
        repeat (3) @(posedge clk);
        check("pending results", exp_q.size(), 32'h0);
        complete_run();
    end
endmodule

//--- test/xfe_regfile_model.sv
// partner model: the two register file read ports feeding the xor slice
// assumes the bench changes the salt word every cycle so each read is fresh
module xfe_regfile_model
(
    input  wire logic [4:0]  rd_a_idx_in,
    input  wire logic [4:0]  rd_b_idx_in,
    input  wire logic [31:0] salt_in,
    output logic [31:0]      rd_a_out,
    output logic [31:0]      rd_b_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // each register reads as the salt rotated left by its own index
    assign rd_a_out = 32'({salt_in, salt_in} >> (6'h20 - {1'b0, rd_a_idx_in}));
    assign rd_b_out = 32'({salt_in, salt_in} >> (6'h20 - {1'b0, rd_b_idx_in}));
endmodule
